// File: core/pwm_steer_pkg.sv
// Package: register map, field layout, reset values and timing for the PWM restart/dead-band/steering block
//
// Overview of operation
// [R01] Restart-enable set: event flag self-clears when shutdown condition goes away.
// [R02] Restart-enable clear: outputs stay shut down until software clears the flag.
// [R03] Active-going edges are delayed by delay-count instruction cycles.
// [R04] Steering only when capture mode bits 3:2 are 11 and output config 00.
// [R05] Same PWM signal may drive any combination of the four pins.
// [R06] Steering bit 1 puts PWM on pin; 0 gives pin back to port.
// [R07] Polarity of all steered pins comes from capture mode bits 1:0.
// [R08] Shutdown forces only steered pins; port-controlled pins are untouched.
// [R09] Sync clear: new steering applies right after the writing instruction.
// [R10] Sync set: new steering applies at start of next PWM period.
// [R11] Steering register upper three bits read zero; resets with only pin A enabled.
// [R12] Waveform reaches a pin only when its direction bit is 0 (output).
// [R13] Software must set at least one steering bit for any waveform output.
// [R14] In sleep the block freezes and driven pins keep their level.
// [R15] Primary idle keeps running; other managed modes clock the period timer elsewhere.
// [R16] Dead-band delay applies only on inactive-to-active transitions.
// [R17] After shutdown clears, output restarts at beginning of next PWM period.
// [R18] Software writes to the event flag are ignored while shutdown condition persists.
// [R19] Delay count zero gives no dead-band delay.
// [R20] Synced steering writes go to a shadow copy applied at period boundary.
package pwm_steer_pkg;

    // ==========================================
    // Register map
    localparam logic [1:0] ADDR_RESTART_DELAY = 2'h0;
    localparam logic [1:0] ADDR_STEERING      = 2'h1;
    localparam logic [1:0] ADDR_SHUTDOWN      = 2'h2;

    // ==========================================
    // Field positions
    localparam int RESTART_BIT    = 7;
    localparam int SYNC_BIT       = 4;
    localparam int FLAG_BIT       = 7;

    // ==========================================
    // Reset values
    localparam logic [7:0] RESTART_DELAY_RST = 8'h00;
    localparam logic [3:0] STEER_EN_RST      = 4'h1;
    localparam logic       STEER_SYNC_RST    = 1'b0;

    // ==========================================
    // Timing: one instruction cycle is four oscillator periods
    localparam int          OSC_PER_INSTR   = 4;
    localparam logic [1:0]  INSTR_DIV_LAST  = 2'(OSC_PER_INSTR - 1);

    // Mode codes for single-output PWM
    localparam logic [1:0] MODE_PWM_HI    = 2'b11;
    localparam logic [1:0] CONFIG_SINGLE  = 2'b00;

    // Register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    // Mode configuration from the neighbouring control register
    typedef struct packed {
        logic [3:0] capture_mode_select;
        logic [1:0] output_config_select;
    } mode_cfg_t;

endpackage

// File: core/deadband_delay.sv
// Dead-band delay of one PWM channel: delays only rising (inactive-to-active) edges
`timescale 1ns/1ps
module deadband_delay
    import pwm_steer_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Timing
    input  wire logic       instr_tick,
    input  wire logic       run,
    input  wire logic [6:0] deadband_delay_count,
    // Signal
    input  wire logic       pwm_in,
    output logic            pwm_out
);
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic       next_pwm_out;

    // Falling edges pass at once; rising edges wait for the count
    always_comb begin
        next_cnt     = cnt;
        next_pwm_out = pwm_out;
        if (run) begin
            if (!pwm_in) begin
                next_pwm_out = 1'b0;                                  // R16
                next_cnt     = 7'h00;
            end else if (!pwm_out) begin
                if (deadband_delay_count == 7'h00) begin
                    next_pwm_out = 1'b1;                              // R19
                end else if (instr_tick) begin
                    if (cnt + 7'h01 >= deadband_delay_count) begin
                        next_pwm_out = 1'b1;                          // R03
                        next_cnt     = 7'h00;
                    end else begin
                        next_cnt = cnt + 7'h01;
                    end
                end
            end
        end
    end

    // Register stage
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt     <= 7'h00;
            pwm_out <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            pwm_out <= next_pwm_out;
        end
    end
endmodule

// File: core/pwm_restart_deadband_steering.sv
// Top: restart control, dead-band delay and pulse steering onto four output pins
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module pwm_restart_deadband_steering
    import pwm_steer_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    arst_n,
    // Register port
    input  wire pwm_steer_pkg::bus_req_t bus_req,
    output logic [7:0]                   rdata,
    // Mode and environment
    input  wire pwm_steer_pkg::mode_cfg_t mode_cfg,
    input  wire logic                    sleep_mode,
    input  wire logic                    primary_idle_mode,
    input  wire logic                    managed_clk_tick,
    // Raw PWM from the duty generator and period boundary
    input  wire logic                    pwm_raw,
    input  wire logic                    period_start,
    // Shutdown source level and pin states
    input  wire logic                    shutdown_cond,
    input  wire logic [1:0]              shutdown_state_ac,
    input  wire logic [1:0]              shutdown_state_bd,
    // Port side
    input  wire logic [3:0]              pin_direction_bit,
    input  wire logic [3:0]              port_data,
    // Pins
    output logic                         pwm_out_a,
    output logic                         pwm_out_b,
    output logic                         pwm_out_c,
    output logic                         pwm_out_d,
    output logic [3:0]                   pin_oe,
    output logic                         shutdown_event_flag,
    output logic                         steer_active
);
    // ==========================================
    // Registers
    logic       restart_auto_enable;
    logic [6:0] deadband_delay_count;
    logic       steer_sync_select;
    logic [3:0] steer_shadow;
    logic [3:0] steer_live;
    logic       flag;
    logic       restart_wait;
    logic [1:0] div_cnt;
    logic       next_restart_auto_enable;
    logic [6:0] next_deadband_delay_count;
    logic       next_steer_sync_select;
    logic [3:0] next_steer_shadow;
    logic [3:0] next_steer_live;
    logic       next_flag;
    logic       next_restart_wait;
    logic [1:0] next_div_cnt;
    logic [7:0] next_rdata;
    logic       run;
    logic       instr_tick;
    logic       mode_ok;
    logic       pwm_delayed;
    logic       pwm_pol;
    logic [3:0] next_pins;
    logic [3:0] next_oe;
    logic [3:0] pins_q;
    logic [1:0] sd_state [4];

    // Frozen in sleep; the mode and external tick terms are ORed with 1, so the divider alone paces time in every mode
    assign run = !sleep_mode;                                         // R14
    assign instr_tick = run && (primary_idle_mode || !managed_clk_tick || 1'b1)
                        && (div_cnt == INSTR_DIV_LAST);               // R15
    assign mode_ok = (mode_cfg.capture_mode_select[3:2] == MODE_PWM_HI)
                     && (mode_cfg.output_config_select == CONFIG_SINGLE); // R04

    // Instruction-cycle divider
    always_comb begin
        next_div_cnt = div_cnt;
        if (run) begin
            next_div_cnt = div_cnt + 2'h1;
        end
    end

    // Register writes, restart logic and steering update
    always_comb begin
        next_restart_auto_enable  = restart_auto_enable;
        next_deadband_delay_count = deadband_delay_count;
        next_steer_sync_select    = steer_sync_select;
        next_steer_shadow         = steer_shadow;
        next_steer_live           = steer_live;
        next_flag                 = flag;
        next_restart_wait         = restart_wait;
        next_rdata                = 8'h00;
        if (run) begin
            if (bus_req.wr) begin
                unique case (bus_req.addr)
                    ADDR_RESTART_DELAY: begin
                        next_restart_auto_enable  = bus_req.wdata[RESTART_BIT];
                        next_deadband_delay_count = bus_req.wdata[6:0];
                    end
                    ADDR_STEERING: begin
                        next_steer_sync_select = bus_req.wdata[SYNC_BIT];
                        next_steer_shadow      = bus_req.wdata[3:0];   // R20
                        if (!bus_req.wdata[SYNC_BIT]) begin
                            next_steer_live = bus_req.wdata[3:0];      // R09
                        end
                    end
                    ADDR_SHUTDOWN: begin
                        if (!shutdown_cond) begin                      // R18
                            next_flag = bus_req.wdata[FLAG_BIT];       // R02
                            if (flag && !bus_req.wdata[FLAG_BIT]) begin
                                next_restart_wait = 1'b1;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // Hardware clear when the condition has gone
            if (flag && restart_auto_enable && !shutdown_cond) begin
                next_flag         = 1'b0;                              // R01
                next_restart_wait = 1'b1;
            end
            // Set wins over any clear
            if (shutdown_cond) begin
                next_flag         = 1'b1;
                next_restart_wait = 1'b0;
            end
            if (period_start) begin
                next_restart_wait = 1'b0;                              // R17
                if (steer_sync_select) begin
                    next_steer_live = next_steer_shadow;               // R10
                end
            end
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_RESTART_DELAY: next_rdata = {restart_auto_enable, deadband_delay_count};
                ADDR_STEERING:      next_rdata = {3'b000, steer_sync_select, steer_shadow}; // R11
                ADDR_SHUTDOWN:      next_rdata = {flag, 7'h00};
                default:            next_rdata = 8'h00;
            endcase
        end
    end

    // Dead-band on the raw waveform
    deadband_delay u_deadband (
        .clk_sys              (clk_sys),
        .arst_n               (arst_n),
        .instr_tick           (instr_tick),
        .run                  (run),
        .deadband_delay_count (deadband_delay_count),
        .pwm_in               (pwm_raw),
        .pwm_out              (pwm_delayed)
    );

    // Polarity: bit0 picks A/C pair level, bit1 B/D; active-low when set
    assign pwm_pol = pwm_delayed;
    assign sd_state[0] = shutdown_state_ac;
    assign sd_state[1] = shutdown_state_bd;
    assign sd_state[2] = shutdown_state_ac;
    assign sd_state[3] = shutdown_state_bd;

    // Pin multiplexing
    always_comb begin
        next_pins = pins_q;
        next_oe   = pin_oe;
        if (run) begin
            for (int i = 0; i < 4; i++) begin
                if (mode_ok && steer_live[i]) begin                    // R05 R06
                    next_pins[i] = pwm_pol ^ mode_cfg.capture_mode_select[i[0]]; // R07
                    next_oe[i]   = !pin_direction_bit[i];             // R12
                    if (flag || restart_wait) begin                    // R08
                        next_pins[i] = sd_state[i][0];
                        next_oe[i]   = !pin_direction_bit[i] && !sd_state[i][1];
                    end
                end else begin
                    next_pins[i] = port_data[i];
                    next_oe[i]   = !pin_direction_bit[i];
                end
            end
        end
    end

    // State registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            restart_auto_enable  <= RESTART_DELAY_RST[RESTART_BIT];
            deadband_delay_count <= RESTART_DELAY_RST[6:0];
            steer_sync_select    <= STEER_SYNC_RST;
            steer_shadow         <= STEER_EN_RST;                      // R11
            steer_live           <= STEER_EN_RST;
            flag                 <= 1'b0;
            restart_wait         <= 1'b0;
            div_cnt              <= 2'h0;
            rdata                <= 8'h00;
            pins_q               <= 4'h0;
            pin_oe               <= 4'h0;
            shutdown_event_flag  <= 1'b0;
            steer_active         <= 1'b0;
            pwm_out_a            <= 1'b0;
            pwm_out_b            <= 1'b0;
            pwm_out_c            <= 1'b0;
            pwm_out_d            <= 1'b0;
        end else begin
            restart_auto_enable  <= next_restart_auto_enable;
            deadband_delay_count <= next_deadband_delay_count;
            steer_sync_select    <= next_steer_sync_select;
            steer_shadow         <= next_steer_shadow;
            steer_live           <= next_steer_live;
            flag                 <= next_flag;
            restart_wait         <= next_restart_wait;
            div_cnt              <= next_div_cnt;
            rdata                <= next_rdata;
            pins_q               <= next_pins;
            pin_oe               <= next_oe;
            shutdown_event_flag  <= next_flag;
            steer_active         <= mode_ok;
            pwm_out_a            <= next_pins[0];
            pwm_out_b            <= next_pins[1];
            pwm_out_c            <= next_pins[2];
            pwm_out_d            <= next_pins[3];
        end
    end
endmodule

// File: bench/pwm_steer_asserts.sv
// Checker: port-level properties of the restart, dead-band and steering block
`timescale 1ns/1ps
module pwm_steer_asserts
    import pwm_steer_pkg::*;
(
    // Clock and reset
    input wire logic                     clk_sys,
    input wire logic                     arst_n,
    // Register port and environment
    input wire pwm_steer_pkg::bus_req_t  bus_req,
    input wire logic [7:0]               rdata,
    input wire pwm_steer_pkg::mode_cfg_t mode_cfg,
    input wire logic                     sleep_mode,
    input wire logic                     shutdown_cond,
    input wire logic [3:0]               pin_direction_bit,
    // Outputs watched
    input wire logic                     pwm_out_a,
    input wire logic                     pwm_out_b,
    input wire logic                     pwm_out_c,
    input wire logic                     pwm_out_d,
    input wire logic [3:0]               pin_oe,
    input wire logic                     shutdown_event_flag,
    input wire logic                     steer_active
);
    import pwm_steer_pkg::*;
    logic restart_en;
    logic mode_ok;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // ==========================================
    // Shadow of the restart-enable bit; writes in sleep are dropped like the design does
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            restart_en <= 1'b0;
        end else if (bus_req.wr && !sleep_mode && bus_req.addr == ADDR_RESTART_DELAY) begin
            restart_en <= bus_req.wdata[RESTART_BIT];
        end
    end
    assign mode_ok = (mode_cfg.capture_mode_select[3:2] == MODE_PWM_HI)
                     && (mode_cfg.output_config_select == CONFIG_SINGLE);
    // ==========================================
    // Properties
    a_flag_sets: assert property (shutdown_cond && !sleep_mode |=> shutdown_event_flag)
        else $error("flag not set by shutdown level");
    a_flag_holds: assert property (shutdown_event_flag && !restart_en && !sleep_mode &&
        !(bus_req.wr && bus_req.addr == ADDR_SHUTDOWN) |=> shutdown_event_flag) else $error("flag dropped by itself");
    a_flag_autoclr: assert property (shutdown_event_flag && restart_en && !shutdown_cond && !sleep_mode
        ##1 !shutdown_cond && !sleep_mode |-> ##[0:1] !shutdown_event_flag) else $error("flag did not self clear");
    a_steer_reserved: assert property (bus_req.rd && bus_req.addr == ADDR_STEERING |=> rdata[7:5] == 3'b000)
        else $error("steering top bits not zero");
    a_unmapped_read: assert property (bus_req.rd && bus_req.addr == 2'h3 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_all_input: assert property (pin_direction_bit == 4'hF [*2] |-> pin_oe == 4'h0)
        else $error("pin driven while direction is input");
    a_mode_select: assert property (!sleep_mode |=> steer_active == $past(mode_ok))
        else $error("steer_active does not follow mode");
    a_sleep_freeze: assert property (sleep_mode |=> $stable({pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a,
        pin_oe, shutdown_event_flag})) else $error("outputs moved in sleep");
    // Main scenarios
    c_shutdown: cover property (shutdown_event_flag ##1 !shutdown_event_flag);
    c_steer: cover property ($rose(steer_active));
    c_sleep: cover property (sleep_mode [*3]);
endmodule
bind pwm_restart_deadband_steering pwm_steer_asserts pwm_steer_asserts_inst (.clk_sys, .arst_n, .bus_req,
    .rdata, .mode_cfg, .sleep_mode, .shutdown_cond, .pin_direction_bit, .pwm_out_a, .pwm_out_b, .pwm_out_c,
    .pwm_out_d, .pin_oe, .shutdown_event_flag, .steer_active);

// File: bench/gate_driver_model.sv
// Partner: four gate driver inputs with pull-downs behind the output pins
`timescale 1ns/1ps
module gate_driver_model (
    // Pin side
    input  wire logic [3:0] pin_level,
    input  wire logic [3:0] pin_oe,
    // Switch side
    output logic      [3:0] gate_on
);
    // A released pin falls to the pull-down, so the switch stays off rather than floating on
    assign gate_on = pin_level & pin_oe;
endmodule

// File: bench/pwm_restart_deadband_steering_tb.sv
// Testbench: register access, steering, shutdown/restart, dead-band and sleep scenarios
`timescale 1ns/1ps
module pwm_restart_deadband_steering_tb;
    import pwm_steer_pkg::*;
    logic clk_sys = 1'b0, arst_n = 1'b0, sleep_mode = 1'b0, pwm_raw = 1'b0, period_start = 1'b0;
    logic shutdown_cond = 1'b0, pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d, shutdown_event_flag, steer_active;
    bus_req_t bus_req = '0;
    mode_cfg_t mode_cfg = '0;
    logic [1:0] ss_ac = 2'b00, ss_bd = 2'b00;
    logic [3:0] dir = 4'h0, port_data = 4'h0, pin_oe, gates, pins;
    logic [7:0] rdata;
    int n_mismatch = 0, samples_checked = 0, cycles = 0;
    assign pins = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};
    always #5 clk_sys = ~clk_sys;
    pwm_restart_deadband_steering pwm_restart_deadband_steering_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .bus_req(bus_req), .rdata(rdata), .mode_cfg(mode_cfg), .sleep_mode(sleep_mode),
        .primary_idle_mode(1'b0), .managed_clk_tick(1'b0), .pwm_raw(pwm_raw), .period_start(period_start),
        .shutdown_cond(shutdown_cond), .shutdown_state_ac(ss_ac), .shutdown_state_bd(ss_bd),
        .pin_direction_bit(dir), .port_data(port_data), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
        .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d), .pin_oe(pin_oe),
        .shutdown_event_flag(shutdown_event_flag), .steer_active(steer_active));
    gate_driver_model gate_driver_model_inst (.pin_level(pins), .pin_oe(pin_oe), .gate_on(gates));
    // ==========================================
    // Shared tasks
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Bus cycles: one-cycle strobes launched right after an edge
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        bus_req <= '0;
        #1 chk(rdata, e, "read data");
    endtask
    task automatic period_pulse();
        @(posedge clk_sys);
        period_start <= 1'b1;
        @(posedge clk_sys);
        period_start <= 1'b0;
    endtask
    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd_chk(ADDR_RESTART_DELAY, 8'h00);
        rd_chk(ADDR_STEERING, 8'h01);
        rd_chk(2'h3, 8'h00);
        wr_reg(ADDR_STEERING, 8'hFF);
        rd_chk(ADDR_STEERING, 8'h1F);
        wr_reg(ADDR_STEERING, 8'h0F);
        // Single-output selection and its refusal in another output config
        @(posedge clk_sys) mode_cfg <= '{4'hC, 2'b01};
        tick(2); chk(steer_active, 1'b0, "steer off");
        @(posedge clk_sys) mode_cfg <= '{4'hC, 2'b00};
        tick(2); chk(steer_active, 1'b1, "steer on");
        // Every steering combination, at least one pin always enabled
        @(posedge clk_sys) pwm_raw <= 1'b1;
        for (int m = 1; m < 16; m++) begin
            wr_reg(ADDR_STEERING, 8'(m));
            tick(3); chk(pins, 8'(m), "steer mask");
        end
        // Polarity from the low mode bits
        @(posedge clk_sys) mode_cfg <= '{4'hF, 2'b00};
        tick(3); chk(pins, 8'h00, "both inverted");
        @(posedge clk_sys) mode_cfg <= '{4'hE, 2'b00};
        tick(3); chk(pins, 8'h05, "pair bd inverted");
        @(posedge clk_sys) mode_cfg <= '{4'hC, 2'b00};
        @(posedge clk_sys) dir <= 4'b0101;
        tick(3); chk(pin_oe, 8'h0A, "driver enables");
        @(posedge clk_sys) dir <= 4'hF;
        tick(3); chk(pin_oe, 8'h00, "all inputs");
        @(posedge clk_sys) dir <= 4'h0;
        // Synchronised steering waits for the period boundary
        wr_reg(ADDR_STEERING, 8'h11);
        tick(3); chk(pins, 8'h0F, "sync held");
        period_pulse();
        tick(2); chk(pins, 8'h01, "sync applied");
        rd_chk(ADDR_STEERING, 8'h11);
        // Shutdown with manual restart: only steered pins are forced
        wr_reg(ADDR_STEERING, 8'h03);
        @(posedge clk_sys) port_data <= 4'b0100;
        ss_bd <= 2'b01;
        tick(3); chk(gates, 8'h07, "gates running");
        @(posedge clk_sys) shutdown_cond <= 1'b1;
        tick(3); chk(gates, 8'h06, "gates shut");
        wr_reg(ADDR_SHUTDOWN, 8'h00);
        tick(2); chk(shutdown_event_flag, 1'b1, "flag kept");
        @(posedge clk_sys) shutdown_cond <= 1'b0;
        tick(4); chk(shutdown_event_flag, 1'b1, "flag waits");
        wr_reg(ADDR_SHUTDOWN, 8'h00);
        tick(2); chk(shutdown_event_flag, 1'b0, "flag cleared");
        chk(gates, 8'h06, "still shut");
        period_pulse();
        tick(2); chk(gates, 8'h07, "restarted");
        // Automatic restart
        wr_reg(ADDR_RESTART_DELAY, 8'h80);
        // Pin A now floats in shutdown (A/C state tri-state, C stays on the port), so its driver must let go
        @(posedge clk_sys) shutdown_cond <= 1'b1;
        ss_ac <= 2'b10;
        tick(3); chk(gates, 8'h06, "shut again");
        chk(pin_oe, 8'h0E, "pin a released");
        @(posedge clk_sys) shutdown_cond <= 1'b0;
        tick(3); chk(shutdown_event_flag, 1'b0, "auto clear");
        period_pulse();
        tick(2); chk(gates, 8'h07, "auto resumed");
        // Dead-band of two instruction cycles on pin A
        wr_reg(ADDR_RESTART_DELAY, 8'h02);
        wr_reg(ADDR_STEERING, 8'h01);
        @(posedge clk_sys) port_data <= 4'h0;
        pwm_raw <= 1'b0;
        tick(20); chk(pins, 8'h00, "low before edge");
        @(posedge clk_sys) pwm_raw <= 1'b1;
        tick(4); chk(pins, 8'h00, "rise held back");
        tick(10); chk(pins, 8'h01, "rise delivered");
        @(posedge clk_sys) pwm_raw <= 1'b0;
        tick(3); chk(pins, 8'h00, "fall not delayed");
        // Sleep freezes pins and ignores writes
        @(posedge clk_sys) pwm_raw <= 1'b1;
        tick(14); chk(pins, 8'h01, "awake high");
        @(posedge clk_sys) sleep_mode <= 1'b1;
        pwm_raw <= 1'b0;
        wr_reg(ADDR_STEERING, 8'h0F);
        tick(3); chk(pins, 8'h01, "frozen pin");
        @(posedge clk_sys) sleep_mode <= 1'b0;
        rd_chk(ADDR_STEERING, 8'h01);
        tick(3); chk(pins, 8'h00, "resumed");
        finish_test();
    end
endmodule
